//--- hw/pwmtb_consts.svh
`ifndef PWMTB_CONSTS_SVH
`define PWMTB_CONSTS_SVH
// Notes on behaviour
// - bit 15 enables whole module
// - bit 13 halts time base in idle
// - bit 12 reads special event pending
// - bit 11 gates special event interrupt
// - bit 10 immediate period update, else boundary
// - bit 9 makes sync pins active low
// - bit 8 enables sync output pulse
// - bit 7 enables external sync reset
// - bits 6-4 select sync input one-four
// - postscaler fires every N+1 matches
// - center-aligned steps coarsened to eight ticks
// - finest resolution is one counter tick
// - bit 14 reads zero, ignores writes
// - compare bits 15-3 match counter, feed postscaler

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PWMTB_ADDR_CTRL 12'h000
`define PWMTB_ADDR_PER 12'h004
`define PWMTB_ADDR_CMP 12'h008
`define PWMTB_ADDR_CNT 12'h00C
`define PWMTB_ADDR_IRQ_STAT 12'h010
`define PWMTB_ADDR_IRQ_EN 12'h014
`define PWMTB_ADDR_IRQ_CLR 12'h018
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define PWMTB_CTRL_WMASK 16'hAFFF
`define PWMTB_CTRL_RST 16'h0000
`define PWMTB_PER_RST 16'hFFF8
`define PWMTB_CMP_RST 16'h0000
`define PWMTB_CMP_MASK 16'hFFF8
`define PWMTB_CENTER_MASK 16'hFFF8
`define PWMTB_NUM_SYNC 4
`define PWMTB_IRQ_BITS 2
`endif

//--- hw/pwmtb_pkg.sv
package pwmtb_pkg;
  typedef struct packed {
    logic moduleEnable;
    logic unused14;
    logic idleHalt;
    logic eventPending;
    logic eventIrqEnable;
    logic immediatePeriodUpdate;
    logic syncPolarityInvert;
    logic syncOutputEnable;
    logic externalSyncEnable;
    logic [2:0] syncSourceSelect;
    logic [3:0] specialEventPostscale;
  } pwmtb_ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pwmtb_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pwmtb_apb_rsp_t;

  typedef enum logic [1:0] {
    PWMTB_IDLE = 2'b00,
    PWMTB_RUN = 2'b01,
    PWMTB_HALT = 2'b11
  } pwmtb_state_t;
endpackage

//--- hw/pwmtb_sync_sel.sv
`timescale 1ns/1ps
`include "pwmtb_consts.svh"
module pwmtb_sync_sel (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`PWMTB_NUM_SYNC-1:0] syncInputN,
  input wire logic [2:0] syncSourceSelect,
  input wire logic syncPolarityInvert,
  output logic syncPulse
);
  import pwmtb_pkg::*;
  typedef struct packed {
    logic prevLevel;
  } pwmtb_sel_state_t;
  pwmtb_sel_state_t st_r;
  pwmtb_sel_state_t st_nxt;
  logic level;

  always_comb begin
    st_nxt = st_r;
    // reserved codes never synchronise
    if (syncSourceSelect[2]) begin
      level = 1'b0;
    end else begin
      level = syncInputN[syncSourceSelect[1:0]] ^ syncPolarityInvert;
    end
    st_nxt.prevLevel = level;
    syncPulse = level & ~st_r.prevLevel;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

//--- hw/pwmtb_postscale.sv
`timescale 1ns/1ps
module pwmtb_postscale (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic match,
  input wire logic [3:0] ratio,
  output logic trigger
);
  import pwmtb_pkg::*;
  typedef struct packed {
    logic [3:0] count;
  } pwmtb_ps_state_t;
  pwmtb_ps_state_t st_r;
  pwmtb_ps_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    trigger = 1'b0;
    if (clear) begin
      st_nxt.count = 4'h0;
    end else if (match) begin
      if (st_r.count >= ratio) begin
        trigger = 1'b1;
        st_nxt.count = 4'h0;
      end else begin
        st_nxt.count = st_r.count + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

//--- hw/pwmtb_top.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pwmtb_consts.svh"
module pwmtb_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire pwmtb_pkg::pwmtb_apb_req_t apbReq,
  output pwmtb_pkg::pwmtb_apb_rsp_t apbRsp,
  input wire logic cpuIdle,
  input wire logic centerAligned,
  input wire logic [`PWMTB_NUM_SYNC-1:0] syncInputN,
  output logic syncOutputPulse,
  output logic specialEventTrigger,
  output logic moduleEnabled,
  output logic [15:0] primaryMasterCounter,
  output logic irq
);
  import pwmtb_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pwmtb_ctrl_t ctrl;
    logic [15:0] periodBuf;
    logic [15:0] periodActive;
    logic [15:0] compareValue;
    logic [15:0] counter;
    logic [1:0] irqStatus;
    logic [1:0] irqEnable;
    pwmtb_state_t mode;
    pwmtb_apb_rsp_t rsp;
    logic syncOut;
    logic trig;
    logic enOut;
    logic irqOut;
  } pwmtb_top_state_t;

  pwmtb_top_state_t st_r;
  pwmtb_top_state_t st_nxt;
  logic syncPulse;
  logic cmpMatch;
  logic trigger;
  logic running;
  logic wrAccess;
  logic rdAccess;
  logic wrap;
  logic [15:0] wdata16;
  logic [15:0] stepSize;

  function automatic logic [15:0] quantize(input logic [15:0] v, input logic center);
    // center-aligned drops the three finest bits
    quantize = center ? (v & `PWMTB_CENTER_MASK) : v;
  endfunction

  pwmtb_sync_sel u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .syncInputN(syncInputN),
    .syncSourceSelect(st_r.ctrl.syncSourceSelect),
    .syncPolarityInvert(st_r.ctrl.syncPolarityInvert),
    .syncPulse(syncPulse)
  );

  pwmtb_postscale u_ps (
    .core_clk(core_clk),
    .rst(rst),
    .clear(~st_r.ctrl.moduleEnable),
    .match(cmpMatch),
    .ratio(st_r.ctrl.specialEventPostscale),
    .trigger(trigger)
  );

  assign wrAccess = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign rdAccess = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
  assign wdata16 = apbReq.pwdata[15:0];
  assign running = (st_r.mode == PWMTB_RUN);
  assign stepSize = centerAligned ? 16'h0008 : 16'h0001;
  assign wrap = (st_r.counter >= quantize(st_r.periodActive, centerAligned));
  // compare also needs the three low counter bits to be zero
  assign cmpMatch = running &
    ((st_r.counter & `PWMTB_CMP_MASK) == quantize(st_r.compareValue, centerAligned)) &
    ((st_r.counter & ~`PWMTB_CMP_MASK) == 16'h0000);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.syncOut = 1'b0;
    st_nxt.trig = trigger;

    // ---------- time base mode ----------
    case (st_r.mode)
      PWMTB_IDLE: begin
        if (st_r.ctrl.moduleEnable) begin
          st_nxt.mode = PWMTB_RUN;
        end
      end
      PWMTB_RUN: begin
        if (!st_r.ctrl.moduleEnable) begin
          st_nxt.mode = PWMTB_IDLE;
        end else if (cpuIdle && st_r.ctrl.idleHalt) begin
          st_nxt.mode = PWMTB_HALT;
        end
      end
      PWMTB_HALT: begin
        if (!st_r.ctrl.moduleEnable) begin
          st_nxt.mode = PWMTB_IDLE;
        end else if (!(cpuIdle && st_r.ctrl.idleHalt)) begin
          st_nxt.mode = PWMTB_RUN;
        end
      end
      default: begin
        st_nxt.mode = PWMTB_IDLE;
      end
    endcase

    // ---------- counter ----------
    if (!st_r.ctrl.moduleEnable) begin
      st_nxt.counter = 16'h0000;
    end else if (running) begin
      if (st_r.ctrl.externalSyncEnable && syncPulse) begin
        st_nxt.counter = 16'h0000;
      end else if (wrap) begin
        st_nxt.counter = 16'h0000;
        st_nxt.periodActive = st_r.periodBuf;
        st_nxt.syncOut = st_r.ctrl.syncOutputEnable;
      end else begin
        st_nxt.counter = st_r.counter + stepSize;
      end
    end

    // ---------- special event status ----------
    if (trigger) begin
      st_nxt.ctrl.eventPending = 1'b1;
    end else if (running && wrap) begin
      // hardware drops the flag at the next cycle boundary
      st_nxt.ctrl.eventPending = 1'b0;
    end

    // ---------- apb ----------
    st_nxt.rsp.pready = 1'b0;
    st_nxt.rsp.pslverr = 1'b0;
    if (rdAccess) begin
      st_nxt.rsp.prdata = 32'h0000_0000;
      case (apbReq.paddr)
        `PWMTB_ADDR_CTRL: st_nxt.rsp.prdata[15:0] = st_r.ctrl;
        `PWMTB_ADDR_PER: st_nxt.rsp.prdata[15:0] = st_r.periodBuf;
        `PWMTB_ADDR_CMP: st_nxt.rsp.prdata[15:0] = st_r.compareValue;
        `PWMTB_ADDR_CNT: st_nxt.rsp.prdata[15:0] = st_r.counter;
        `PWMTB_ADDR_IRQ_STAT: st_nxt.rsp.prdata[1:0] = st_r.irqStatus;
        `PWMTB_ADDR_IRQ_EN: st_nxt.rsp.prdata[1:0] = st_r.irqEnable;
        `PWMTB_ADDR_IRQ_CLR: st_nxt.rsp.prdata = 32'h0000_0000;
        default: st_nxt.rsp.pslverr = 1'b0;
      endcase
    end
    if (apbReq.psel && !apbReq.penable) begin
      st_nxt.rsp.pready = 1'b1;
      if (!(apbReq.paddr inside {`PWMTB_ADDR_CTRL, `PWMTB_ADDR_PER, `PWMTB_ADDR_CMP,
          `PWMTB_ADDR_CNT, `PWMTB_ADDR_IRQ_STAT, `PWMTB_ADDR_IRQ_EN,
          `PWMTB_ADDR_IRQ_CLR})) begin
        st_nxt.rsp.pslverr = 1'b1;
      end
    end

    if (wrAccess && st_r.rsp.pready) begin
      case (apbReq.paddr)
        `PWMTB_ADDR_CTRL: begin
          // pending flag is hardware owned, bit 14 unimplemented
          st_nxt.ctrl = pwmtb_ctrl_t'((wdata16 & `PWMTB_CTRL_WMASK) |
            (16'(st_nxt.ctrl) & 16'h1000));
        end
        `PWMTB_ADDR_PER: begin
          st_nxt.periodBuf = wdata16;
          if (st_r.ctrl.immediatePeriodUpdate) begin
            st_nxt.periodActive = wdata16;
          end
        end
        `PWMTB_ADDR_CMP: st_nxt.compareValue = wdata16 & `PWMTB_CMP_MASK;
        `PWMTB_ADDR_IRQ_EN: st_nxt.irqEnable = wdata16[1:0];
        `PWMTB_ADDR_IRQ_CLR: st_nxt.irqStatus = st_r.irqStatus & ~wdata16[1:0];
        default: st_nxt.irqEnable = st_nxt.irqEnable;
      endcase
    end

    // ---------- interrupt status: set beats clear ----------
    // bit 0 special event trigger, bit 1 period wrap
    if (trigger && st_r.ctrl.eventIrqEnable) begin
      st_nxt.irqStatus[0] = 1'b1;
    end
    if (running && wrap) begin
      st_nxt.irqStatus[1] = 1'b1;
    end

    // pulse leaves in the programmed polarity, inactive level while quiet
    st_nxt.syncOut = st_nxt.syncOut ^ st_nxt.ctrl.syncPolarityInvert;
    st_nxt.enOut = st_nxt.ctrl.moduleEnable;
    st_nxt.irqOut = |(st_nxt.irqStatus & st_nxt.irqEnable);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.periodBuf <= `PWMTB_PER_RST;
      st_r.periodActive <= `PWMTB_PER_RST;
      st_r.mode <= PWMTB_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign apbRsp = st_r.rsp;
  // polarity applied before the register, output taken straight from it; idles at the inactive level
  assign syncOutputPulse = st_r.syncOut;
  assign specialEventTrigger = st_r.trig;
  assign moduleEnabled = st_r.enOut;
  assign primaryMasterCounter = st_r.counter;
  assign irq = st_r.irqOut;
endmodule

//--- verification/pwmtb_props.sv
`timescale 1ns/1ps
module pwmtb_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire pwmtb_pkg::pwmtb_apb_req_t apbReq,
  input wire pwmtb_pkg::pwmtb_apb_rsp_t apbRsp,
  input wire logic cpuIdle,
  input wire logic centerAligned,
  input wire logic [3:0] syncInputN,
  input wire logic syncOutputPulse,
  input wire logic specialEventTrigger,
  input wire logic moduleEnabled,
  input wire logic [15:0] primaryMasterCounter,
  input wire logic irq
);
  import pwmtb_pkg::*;
  logic [15:0] ctrl_r;
  logic ctrlWr;
  assign ctrlWr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.paddr == 12'h000;
  // ----
  // control word copy, so the modes are visible here
  // ----
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 16'h0000;
    end else if (ctrlWr && apbReq.pwrite) begin
      ctrl_r <= apbReq.pwdata[15:0] & 16'hAFFF;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  off_quiet_a: assert property (!moduleEnabled [*3] |-> !(syncOutputPulse ^ ctrl_r[9])
    && !specialEventTrigger) else $error("pulse while disabled");
  enable_mirror_a: assert property ($stable(ctrl_r[15]) |-> moduleEnabled == ctrl_r[15])
    else $error("enable output differs");
  idle_halt_a: assert property (ctrl_r[15] && $past(ctrl_r[15]) && $past(ctrl_r[15], 2)
    && ctrl_r[13] && $past(ctrl_r[13]) && !ctrl_r[7] && $past(cpuIdle) && cpuIdle
    |=> $stable(primaryMasterCounter)) else $error("counter ran in idle");
  idle_run_a: assert property (ctrl_r[15] && $past(ctrl_r[15], 2) && !ctrl_r[13] && !ctrl_r[7]
    && cpuIdle |=> !$stable(primaryMasterCounter)) else $error("counter stopped");
  sync_reset_a: assert property (ctrl_r[15] && ctrl_r[7] && !ctrl_r[6]
    && $rose(syncInputN[ctrl_r[5:4]] ^ ctrl_r[9]) |-> ##[1:3] primaryMasterCounter == 16'h0000)
    else $error("sync did not clear counter");
  syncout_off_a: assert property (!ctrl_r[8] && !$past(ctrl_r[8])
    |-> !(syncOutputPulse ^ ctrl_r[9])) else $error("sync output while off");
  syncout_pulse_a: assert property ((syncOutputPulse ^ ctrl_r[9])
    |=> !(syncOutputPulse ^ ctrl_r[9])) else $error("sync output too long");
  ctrl_read_a: assert property (ctrlWr && !apbReq.pwrite |-> apbRsp.prdata[31:13] ==
    {16'h0000, ctrl_r[15], 1'h0, ctrl_r[13]} && apbRsp.prdata[11:0] == ctrl_r[11:0])
    else $error("control read wrong");
endmodule
bind pwmtb_top pwmtb_props i_pwmtb_props (.core_clk(core_clk), .rst(rst), .apbReq(apbReq),
  .apbRsp(apbRsp), .cpuIdle(cpuIdle), .centerAligned(centerAligned), .syncInputN(syncInputN),
  .syncOutputPulse(syncOutputPulse), .specialEventTrigger(specialEventTrigger),
  .moduleEnabled(moduleEnabled), .primaryMasterCounter(primaryMasterCounter), .irq(irq));

//--- verification/pwmtb_sync_src.sv
`timescale 1ns/1ps
module pwmtb_sync_src (
  input wire logic core_clk,
  input wire logic fire,
  input wire logic [1:0] line,
  input wire logic activeLow,
  output logic [3:0] syncInputN
);
  logic [1:0] left_r = 2'h0;
  // ----
  // sync source
  // ----
  // two-cycle pulse so a registered edge detector cannot miss it
  always @(posedge core_clk) begin
    left_r <= fire ? 2'h2 : left_r - {1'h0, left_r != 2'h0};
  end
  assign syncInputN = {4{activeLow}} ^ ((left_r != 2'h0) ? (4'h1 << line) : 4'h0);
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pwmtb_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  pwmtb_apb_req_t req = '0;
  pwmtb_apb_rsp_t rsp;
  logic cpuIdle = 1'h0;
  logic center = 1'h0;
  logic fire = 1'h0;
  logic activeLow = 1'h0;
  logic [1:0] line = 2'h0;
  logic [3:0] syncIn, ps;
  logic syncOut, trig, enab, irq, err;
  logic [15:0] cnt, v, a;
  logic [2:0] src;
  logic [31:0] rd;
  int miscompares = 0;
  int samples_checked = 0;
  int k, n, m;
  always #10 core_clk = ~core_clk;
  pwmtb_top i_pwmtb_top (.core_clk(core_clk), .rst(rst), .apbReq(req), .apbRsp(rsp),
    .cpuIdle(cpuIdle), .centerAligned(center), .syncInputN(syncIn), .syncOutputPulse(syncOut),
    .specialEventTrigger(trig), .moduleEnabled(enab), .primaryMasterCounter(cnt), .irq(irq));
  pwmtb_sync_src i_pwmtb_sync_src (.core_clk(core_clk), .fire(fire), .line(line),
    .activeLow(activeLow), .syncInputN(syncIn));
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bail(input int c);
    if (c > 3000) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge core_clk);
    req <= '{1'h1, 1'h0, w, ad, d};
    @(posedge core_clk);
    req.penable <= 1'h1;
    do begin
      @(posedge core_clk);
      c++;
      bail(c);
    end while (rsp.pready !== 1'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask
  task automatic wait_count(input logic [15:0] t);
    int c;
    c = 0;
    while (cnt < t) begin
      @(posedge core_clk);
      c++;
      bail(c);
    end
  endtask
  // enable: setup, then the same word with the module switched on
  task automatic start(input logic [15:0] w);
    apb(1'h1, 12'h000, {16'h0, w});
    apb(1'h1, 12'h000, {16'h0, w | 16'h8000});
  endtask
  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(96725));
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    for (k = 0; k < 4; k++) begin
      apb(1'h0, 12'(k * 4), 32'h0);
      chk("reset value", rd, (k == 1) ? 32'h0000FFF8 : 32'h0);
    end
    apb(1'h0, 12'h01C, 32'h0);
    chk("unmapped error", {err, rd[30:0]}, 32'h8000_0000);
    for (k = 0; k < 6; k++) begin
      v = 16'($urandom) & 16'h7FFF;
      apb(1'h1, 12'h000, {16'h0, v});
      apb(1'h0, 12'h000, 32'h0);
      chk("control", rd, {16'h0, v & 16'hAFFF});
    end
    $display("register test done");
    apb(1'h1, 12'h000, 32'h400);
    apb(1'h1, 12'h004, 32'h10);
    apb(1'h1, 12'h008, 32'h8);
    apb(1'h1, 12'h014, 32'h1);
    for (k = 0; k < 4; k++) begin
      ps = (k == 3) ? 4'($urandom) : ((k == 2) ? 4'hF : 4'(k));
      start({4'h0, k[0], 2'h0, k[0], 4'h0, ps});
      n = 0;
      m = 0;
      repeat (68 * (ps + 1)) begin
        @(posedge core_clk);
        n += trig;
        m += syncOut;
      end
      apb(1'h1, 12'h000, 32'h0);
      chk("trigger count", n, 4);
      chk("sync output", m > 0, k[0]);
      apb(1'h0, 12'h010, 32'h0);
      chk("event status", {irq, rd[0]}, {2{k[0]}});
      apb(1'h1, 12'h018, 32'h3);
      apb(1'h0, 12'h010, 32'h0);
      chk("status cleared", {irq, rd[1:0]}, 0);
    end
    $display("postscaler test done");
    for (k = 0; k < 2; k++) begin
      apb(1'h1, 12'h000, 32'h400);
      apb(1'h1, 12'h004, 32'h40);
      start(16'(k) << 10);
      wait_count(16'h0030);
      apb(1'h1, 12'h004, 32'h18);
      repeat (2) @(posedge core_clk);
      chk("period update", cnt < 16'h0030, k[0]);
      apb(1'h1, 12'h000, 32'h0);
    end
    $display("period test done");
    for (k = 0; k < 2; k++) begin
      start(16'(k) << 13);
      cpuIdle <= 1'h1;
      repeat (3) @(posedge core_clk);
      a = cnt;
      repeat (6) @(posedge core_clk);
      chk("idle halt", cnt == a, k[0]);
      cpuIdle <= 1'h0;
      apb(1'h1, 12'h000, 32'h0);
    end
    $display("idle test done");
    center <= 1'h1;
    start(16'h0000);
    repeat (3) @(posedge core_clk);
    a = cnt;
    @(posedge core_clk);
    chk("center step", cnt - a, 32'h8);
    chk("center grid", cnt[2:0], 3'h0);
    apb(1'h1, 12'h000, 32'h0);
    center <= 1'h0;
    $display("center test done");
    apb(1'h1, 12'h000, 32'h400);
    apb(1'h1, 12'h004, 32'h40);
    for (k = 0; k < 10; k++) begin
      src = (k % 5 == 4) ? 3'h5 : 3'(k % 5);
      line <= 2'($urandom);
      activeLow <= 1'(k / 5);
      start({6'h0, 1'(k / 5), 2'h1, src, 4'h0});
      wait_count(16'h0014);
      fire <= 1'h1;
      @(posedge core_clk);
      fire <= 1'h0;
      repeat (5) @(posedge core_clk);
      chk("sync clear", cnt < 16'h0010, src == {1'h0, line});
      chk("sync idle level", syncOut, activeLow);
      apb(1'h1, 12'h000, 32'h0);
    end
    $display("sync test done");
    final_report();
  end
endmodule
